//--- rtl/adl_division.sv
// one division of depressurization actuation logic: three redundant channels,
// bypass control, manual arm/fire, majority voting and series firing drivers
// assumes every input except i_srst comes from pins outside i_clock's domain
`timescale 1ns/1ps
`default_nettype none
module adl_division
  import adl_pkg::*;
#(
  parameter int unsigned DIV = 0,
  parameter int unsigned LW = 16,
  parameter longint unsigned LVL_CYC = LVL_SUSTAIN_CYC,
  parameter longint unsigned PRS_CYC = PRS_SUSTAIN_CYC,
  parameter logic [NTMR*32-1:0] GRP_CYC = {NTMR{GRP_DLY_CYC}}
)(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // three digitized copies of level and pressure, and setpoints
  input wire logic [NCH*LW-1:0] i_level,
  input wire logic [NCH*LW-1:0] i_pressure,
  input wire logic [LW-1:0] i_level_sp,
  input wire logic [LW-1:0] i_pressure_sp,
  // votes shared by the other divisions, own slot ignored
  input wire logic [NDIV-1:0] i_peer_lvl_vote,
  input wire logic [NDIV-1:0] i_peer_prs_vote,
  // bypass requests and inhibits
  input wire logic [NDIV-1:0] i_bypass_req,
  input wire logic i_inhibit_transient,
  input wire logic i_inhibit_manual,
  // per-valve manual arm and fire
  input wire logic [NVALVE-1:0] i_valve_arm,
  input wire logic [NVALVE-1:0] i_valve_fire,
  // system-level manual arm and fire, one switch per division
  input wire logic [NDIV-1:0] i_sys_arm,
  input wire logic [NDIV-1:0] i_sys_fire,
  // firing circuit status
  input wire logic [NVALVE-1:0] i_test_sw_closed,
  input wire logic [NVALVE-1:0] i_continuity_ok,
  // shared votes
  output logic o_lvl_vote,
  output logic o_prs_vote,
  // bypass status and alarms
  output logic [NDIV-1:0] o_bypass_active,
  output logic o_bypass_refused,
  output logic o_bypass_alarm,
  output logic o_arm_alarm,
  // sealed actuation and downstream starts
  output logic o_sealed_low_level,
  output logic o_sealed_high_press,
  output logic o_cooling_start,
  output logic o_gravity_cooling_start,
  output logic [NGRP-1:0] o_group_open,
  // load drivers and valve state
  output logic [NRELIEF*RELIEF_DRV-1:0] o_relief_drv,
  output logic [NSQUIB*SQUIB_DRV-1:0] o_squib_drv,
  output logic [NVALVE-1:0] o_valve_energized
);
  localparam int unsigned SW = 2*NCH*LW + 2*LW + 5*NDIV + 2 + 4*NVALVE;

  if (LW < 2 || DIV >= NDIV || LVL_CYC < 1 || PRS_CYC < 1
      || PRS_CYC >= (64'h1 << TW) || LVL_CYC >= (64'h1 << TW)) begin : g_chk
    $error("adl_division: unsupported parameter values");
  end

  // synchronised inputs
  logic [SW-1:0] meta_q;
  logic [SW-1:0] sync_q;
  logic [NCH*LW-1:0] level_s;
  logic [NCH*LW-1:0] press_s;
  logic [LW-1:0] level_sp_s;
  logic [LW-1:0] press_sp_s;
  logic [NDIV-1:0] peer_lvl_s;
  logic [NDIV-1:0] peer_prs_s;
  logic [NDIV-1:0] byp_req_s;
  logic inh_tr_s;
  logic inh_man_s;
  logic [NVALVE-1:0] varm_s;
  logic [NVALVE-1:0] vfire_s;
  logic [NDIV-1:0] sarm_s;
  logic [NDIV-1:0] sfire_s;
  logic [NVALVE-1:0] sw_s;
  logic [NVALVE-1:0] cont_s;

  // bypass
  logic [NDIV-1:0] bypass_q;
  logic refused_q;
  logic byp_alarm_q;

  // manual
  logic [NVALVE-1:0] armed_q;
  logic [NVALVE-1:0] vfire_prev_q;
  logic [NVALVE-1:0] man_open_q;
  logic [NDIV-1:0] sarmed_q;
  logic [NDIV-1:0] sfire_prev_q;
  logic [NDIV-1:0] done_q;
  logic sys_seal_q;
  logic arm_alarm_q;

  // channel results
  logic [NCH-1:0] ch_lvl;
  logic [NCH-1:0] ch_prs;
  logic [NCH-1:0] ch_slvl;
  logic [NCH-1:0] ch_sprs;
  logic [NGRP-1:0] ch_grp [NCH];
  logic [NGRP-1:0] grp_maj;
  logic inhibit;

  // outputs and drivers
  logic lvl_vote_q;
  logic prs_vote_q;
  logic slvl_q;
  logic sprs_q;
  logic cool_q;
  logic grav_q;
  logic [NGRP-1:0] grp_q;
  logic [NVALVE-1:0] cmd;
  logic [NRELIEF*RELIEF_DRV-1:0] relief_d;
  logic [NSQUIB*SQUIB_DRV-1:0] squib_d;
  logic [NVALVE-1:0] energize_d;
  logic [NRELIEF*RELIEF_DRV-1:0] relief_q;
  logic [NSQUIB*SQUIB_DRV-1:0] squib_q;
  logic [NVALVE-1:0] energized_q;

  function automatic logic maj3(input logic [NCH-1:0] a);
    return (a[0] & a[1]) | (a[0] & a[2]) | (a[1] & a[2]);
  endfunction : maj3

  // two flip-flops on every pin; digitizer words are held stable for many cycles
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= {i_level, i_pressure, i_level_sp, i_pressure_sp,
                 i_peer_lvl_vote, i_peer_prs_vote, i_bypass_req,
                 i_inhibit_transient, i_inhibit_manual, i_valve_arm,
                 i_valve_fire, i_sys_arm, i_sys_fire, i_test_sw_closed,
                 i_continuity_ok};
      sync_q <= meta_q;
    end
  end

  assign {level_s, press_s, level_sp_s, press_sp_s, peer_lvl_s, peer_prs_s,
          byp_req_s, inh_tr_s, inh_man_s, varm_s, vfire_s, sarm_s, sfire_s,
          sw_s, cont_s} = sync_q;

  // bypass grant: first single request wins, held until it is withdrawn
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      bypass_q <= '0;
      refused_q <= 1'b0;
      byp_alarm_q <= 1'b0;
    end else begin
      if (bypass_q == '0) begin
        if ($onehot(byp_req_s)) bypass_q <= byp_req_s;
      end else if ((byp_req_s & bypass_q) == '0) begin
        bypass_q <= '0;
      end
      refused_q <= (bypass_q != '0 && (byp_req_s & ~bypass_q) != '0)
                   || (bypass_q == '0 && $countones(byp_req_s) > 1);
      byp_alarm_q <= bypass_q != '0;
    end
  end

  assign inhibit = inh_tr_s | inh_man_s;

  // per-valve arm then fire: fire edge counts only if arm was seen a cycle earlier
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      armed_q <= '0;
      vfire_prev_q <= '0;
      man_open_q <= '0;
    end else begin
      armed_q <= varm_s;
      vfire_prev_q <= vfire_s;
      man_open_q <= man_open_q | (vfire_s & ~vfire_prev_q & armed_q);
    end
  end

  // system initiation from the divisional switches
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      sarmed_q <= '0;
      sfire_prev_q <= '0;
      done_q <= '0;
      sys_seal_q <= 1'b0;
    end else begin
      sarmed_q <= sarm_s;
      sfire_prev_q <= sfire_s;
      done_q <= done_q | (sfire_s & ~sfire_prev_q & sarmed_q);
      if ($countones(done_q) >= MAN_DIV_MIN) sys_seal_q <= 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) arm_alarm_q <= 1'b0;
    else arm_alarm_q <= (varm_s != '0) || (sarm_s != '0);
  end

  // three redundant channels, each on its own digitized copy
  adl_chan_if cbus [NCH] ();

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    adl_channel #(
      .DIV(DIV),
      .LW(LW),
      .LVL_CYC(LVL_CYC),
      .PRS_CYC(PRS_CYC),
      .GRP_CYC(GRP_CYC)
    ) u_ch (
      .i_clock(i_clock),
      .i_srst(i_srst),
      .i_level(level_s[c*LW +: LW]),
      .i_pressure(press_s[c*LW +: LW]),
      .i_level_sp(level_sp_s),
      .i_pressure_sp(press_sp_s),
      .i_peer_lvl(peer_lvl_s),
      .i_peer_prs(peer_prs_s),
      .i_bypass(bypass_q),
      .i_inhibit(inhibit),
      .i_man_start(sys_seal_q),
      .o_bus(cbus[c])
    );
    assign ch_lvl[c] = cbus[c].lvl_vote;
    assign ch_prs[c] = cbus[c].prs_vote;
    assign ch_slvl[c] = cbus[c].sealed_lvl;
    assign ch_sprs[c] = cbus[c].sealed_prs;
    assign ch_grp[c] = cbus[c].grp_open;
  end

  // one faulty channel can neither open nor hold back a group
  assign grp_maj = (ch_grp[0] & ch_grp[1]) | (ch_grp[0] & ch_grp[2])
                   | (ch_grp[1] & ch_grp[2]);

  for (genvar v = 0; v < NVALVE; v++) begin : g_valve
    assign cmd[v] = grp_maj[adl_grp_of(v)] | man_open_q[v];
    if (v < NRELIEF) begin : g_rel
      assign relief_d[v*RELIEF_DRV +: RELIEF_DRV] = {RELIEF_DRV{cmd[v]}};
      assign energize_d[v] = (&relief_d[v*RELIEF_DRV +: RELIEF_DRV])
                             & sw_s[v] & cont_s[v];
    end else begin : g_sq
      localparam int unsigned S = v - NRELIEF;
      assign squib_d[S*SQUIB_DRV +: SQUIB_DRV] = {SQUIB_DRV{cmd[v]}};
      assign energize_d[v] = (&squib_d[S*SQUIB_DRV +: SQUIB_DRV])
                             & sw_s[v] & cont_s[v];
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      lvl_vote_q <= 1'b0;
      prs_vote_q <= 1'b0;
      slvl_q <= 1'b0;
      sprs_q <= 1'b0;
      cool_q <= 1'b0;
      grav_q <= 1'b0;
      grp_q <= '0;
    end else begin
      lvl_vote_q <= maj3(ch_lvl);
      prs_vote_q <= maj3(ch_prs);
      slvl_q <= maj3(ch_slvl);
      sprs_q <= maj3(ch_sprs);
      cool_q <= maj3(ch_slvl);
      grav_q <= maj3(ch_sprs);
      grp_q <= grp_maj;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      relief_q <= '0;
      squib_q <= '0;
      energized_q <= '0;
    end else begin
      relief_q <= relief_d;
      squib_q <= squib_d;
      energized_q <= energize_d;
    end
  end

  assign o_lvl_vote = lvl_vote_q;
  assign o_prs_vote = prs_vote_q;
  assign o_bypass_active = bypass_q;
  assign o_bypass_refused = refused_q;
  assign o_bypass_alarm = byp_alarm_q;
  assign o_arm_alarm = arm_alarm_q;
  assign o_sealed_low_level = slvl_q;
  assign o_sealed_high_press = sprs_q;
  assign o_cooling_start = cool_q;
  assign o_gravity_cooling_start = grav_q;
  assign o_group_open = grp_q;
  assign o_relief_drv = relief_q;
  assign o_squib_drv = squib_q;
  assign o_valve_energized = energized_q;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);

  property p_bypass_one;
    $onehot0(bypass_q);
  endproperty
  a_bypass_one: assert property (p_bypass_one) else $error("two divisions bypassed");

  property p_bypass_alarm;
    bypass_q != '0 |=> o_bypass_alarm;
  endproperty
  a_bypass_alarm: assert property (p_bypass_alarm) else $error("bypass not alarmed");

  property p_arm_alarm;
    varm_s != '0 |=> o_arm_alarm;
  endproperty
  a_arm_alarm: assert property (p_arm_alarm) else $error("arm not alarmed");

  property p_fire_needs_arm;
    ((man_open_q & ~$past(man_open_q)) & ~$past(armed_q)) == '0;
  endproperty
  a_fire_needs_arm: assert property (p_fire_needs_arm) else $error("fire without arm");

  sequence s_two_fired;
    $countones(done_q) >= MAN_DIV_MIN;
  endsequence
  property p_sys_seal;
    s_two_fired |=> sys_seal_q ##1 sys_seal_q;
  endproperty
  a_sys_seal: assert property (p_sys_seal) else $error("system initiation not sealed");

  property p_energize;
    (o_valve_energized & ~$past(sw_s & cont_s)) == '0
      && (o_valve_energized & ~$past(cmd)) == '0;
  endproperty
  a_energize: assert property (p_energize) else $error("valve energized wrongly");

  property p_majority;
    (ch_grp[0] & ch_grp[1]) != '0 |=> (o_group_open & $past(ch_grp[0] & ch_grp[1]))
                                      == $past(ch_grp[0] & ch_grp[1]);
  endproperty
  a_majority: assert property (p_majority) else $error("majority lost a group");

  property p_cool_start;
    o_sealed_low_level |-> o_cooling_start ##1 o_cooling_start;
  endproperty
  a_cool_start: assert property (p_cool_start) else $error("cooling start missing");

  property p_vote_share;
    (ch_lvl == 3'h7) |=> o_lvl_vote;
  endproperty
  a_vote_share: assert property (p_vote_share) else $error("level vote not shared");
endmodule : adl_division
`default_nettype wire

//--- shared/adl_pkg.sv
// constants and types for the divisional depressurization actuation logic
// assumes a 100 MHz i_clock; long timer counts are overridable by top parameters
package adl_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned NDIV = 4;
  localparam int unsigned NCH = 3;
  localparam int unsigned NRELIEF = 10;
  localparam int unsigned NSQUIB = 8;
  localparam int unsigned NVALVE = NRELIEF + NSQUIB;
  localparam int unsigned GRP_RELIEF = 5;
  localparam int unsigned GRP_SQUIB = 2;
  localparam int unsigned NGRP = 6;
  localparam int unsigned NTMR = 5;
  localparam int unsigned RELIEF_DRV = 2;
  localparam int unsigned SQUIB_DRV = 3;
  localparam int unsigned VOTE_MIN = 2;
  localparam int unsigned MAN_DIV_MIN = 2;
  localparam int unsigned TW = 40;
  localparam int unsigned SEC_PER_MIN = 60;
  localparam longint unsigned LVL_SUSTAIN_S = 10;
  localparam longint unsigned PRS_SUSTAIN_MIN = 60;
  localparam longint unsigned GRP_DLY_S = 10;
  localparam longint unsigned LVL_SUSTAIN_CYC = LVL_SUSTAIN_S * CLK_HZ;
  localparam longint unsigned PRS_SUSTAIN_CYC = PRS_SUSTAIN_MIN * SEC_PER_MIN * CLK_HZ;
  localparam logic [31:0] GRP_DLY_CYC = 32'(GRP_DLY_S * CLK_HZ);

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_RUN, SEQ_DONE} adl_seq_e;

  // valve to sequence group: relief valves first, then squib pairs
  function automatic int unsigned adl_grp_of(input int unsigned v);
    if (v < GRP_RELIEF) return 0;
    if (v < NRELIEF) return 1;
    return 2 + (v - NRELIEF) / GRP_SQUIB;
  endfunction : adl_grp_of
endpackage : adl_pkg

//--- shared/adl_chan_if.sv
// carrier from one redundant logic channel to the division voter
// assumes one driver (channel) and one reader (division top)
`timescale 1ns/1ps
`default_nettype none
interface adl_chan_if;
  import adl_pkg::*;
  logic lvl_vote;
  logic prs_vote;
  logic sealed_lvl;
  logic sealed_prs;
  logic [NGRP-1:0] grp_open;
  modport chan (output lvl_vote, prs_vote, sealed_lvl, sealed_prs, grp_open);
  modport top (input lvl_vote, prs_vote, sealed_lvl, sealed_prs, grp_open);
endinterface : adl_chan_if
`default_nettype wire

//--- rtl/adl_channel.sv
// one redundant logic channel: compare, vote, sustain, seal-in, sequencer
// assumes all inputs already synchronised to i_clock
`timescale 1ns/1ps
`default_nettype none
module adl_channel
  import adl_pkg::*;
#(
  parameter int unsigned DIV = 0,
  parameter int unsigned LW = 16,
  parameter longint unsigned LVL_CYC = LVL_SUSTAIN_CYC,
  parameter longint unsigned PRS_CYC = PRS_SUSTAIN_CYC,
  parameter logic [NTMR*32-1:0] GRP_CYC = {NTMR{GRP_DLY_CYC}}
)(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // own measurement copy and setpoints
  input wire logic [LW-1:0] i_level,
  input wire logic [LW-1:0] i_pressure,
  input wire logic [LW-1:0] i_level_sp,
  input wire logic [LW-1:0] i_pressure_sp,
  // shared votes and control
  input wire logic [NDIV-1:0] i_peer_lvl,
  input wire logic [NDIV-1:0] i_peer_prs,
  input wire logic [NDIV-1:0] i_bypass,
  input wire logic i_inhibit,
  input wire logic i_man_start,
  // results
  adl_chan_if.chan o_bus
);
  logic lvl_vote_q;
  logic prs_vote_q;
  logic [NDIV-1:0] lvl_all;
  logic [NDIV-1:0] prs_all;
  logic [1:0] trip;
  logic [TW-1:0] sus_q [2];
  logic sealed_q [2];
  logic start;
  adl_seq_e st_q;
  logic [2:0] stage_q;
  logic [31:0] dly_q;
  logic [NGRP-1:0] open_q;
  logic [31:0] glim [NTMR];

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      lvl_vote_q <= 1'b0;
      prs_vote_q <= 1'b0;
    end else begin
      lvl_vote_q <= i_level < i_level_sp;
      prs_vote_q <= i_pressure > i_pressure_sp;
    end
  end

  always_comb begin
    lvl_all = i_peer_lvl;
    prs_all = i_peer_prs;
    lvl_all[DIV] = lvl_vote_q;
    prs_all[DIV] = prs_vote_q;
    // a bypassed slot never counts, so two of the remaining three still trips
    lvl_all = lvl_all & ~i_bypass;
    prs_all = prs_all & ~i_bypass;
    trip[0] = $countones(lvl_all) >= VOTE_MIN;
    trip[1] = $countones(prs_all) >= VOTE_MIN;
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);

  for (genvar k = 0; k < 2; k++) begin : g_sus
    localparam logic [TW-1:0] LIM = (k == 0) ? TW'(LVL_CYC) : TW'(PRS_CYC);
    always_ff @(posedge i_clock) begin
      if (i_srst) begin
        sus_q[k] <= '0;
        sealed_q[k] <= 1'b0;
      end else if (!trip[k]) begin
        sus_q[k] <= '0;
      end else if (sus_q[k] == LIM - 1'b1) begin
        sealed_q[k] <= 1'b1;
      end else begin
        sus_q[k] <= sus_q[k] + 1'b1;
      end
    end
    property p_sus_clear;
      !trip[k] |=> sus_q[k] == '0;
    endproperty
    a_sus_clear: assert property (p_sus_clear) else $error("sustain timer not cleared");
    property p_seal_time;
      $rose(sealed_q[k]) |-> $past(sus_q[k]) == LIM - 1'b1 && $past(trip[k]);
    endproperty
    a_seal_time: assert property (p_seal_time) else $error("seal before hold time");
  end

  for (genvar t = 0; t < NTMR; t++) begin : g_lim
    assign glim[t] = GRP_CYC[32*t +: 32];
  end

  // inhibit only gates the automatic start, not i_man_start; a sequence already under way completes
  assign start = ((sealed_q[0] || sealed_q[1]) && !i_inhibit) || i_man_start;

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      st_q <= SEQ_IDLE;
      stage_q <= 3'h1;
      dly_q <= '0;
      open_q <= '0;
    end else begin
      case (st_q)
        SEQ_IDLE: begin
          if (start) begin
            open_q[0] <= 1'b1;
            st_q <= SEQ_RUN;
          end
        end
        SEQ_RUN: begin
          if (dly_q >= glim[stage_q - 3'h1] - 32'h1) begin
            open_q[stage_q] <= 1'b1;
            dly_q <= '0;
            if (stage_q == 3'(NGRP - 1)) st_q <= SEQ_DONE;
            else stage_q <= stage_q + 3'h1;
          end else begin
            dly_q <= dly_q + 32'h1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  property p_no_auto_inhibited;
    $rose(open_q[0]) |-> $past(i_man_start) || !$past(i_inhibit);
  endproperty
  a_no_auto_inhibited: assert property (p_no_auto_inhibited) else $error("start under inhibit");
  property p_grp_order;
    open_q[NGRP-1:1] != '0 |-> open_q[0];
  endproperty
  a_grp_order: assert property (p_grp_order) else $error("group opened out of order");

  assign o_bus.lvl_vote = lvl_vote_q;
  assign o_bus.prs_vote = prs_vote_q;
  assign o_bus.sealed_lvl = sealed_q[0];
  assign o_bus.sealed_prs = sealed_q[1];
  assign o_bus.grp_open = open_q;
endmodule : adl_channel
`default_nettype wire

//--- rtl/adl_unused_placeholder_removed.sv
// intentionally empty of logic: no design content
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

//--- verif/adl_sensor_model.sv
// sensor digitizer model: three converter copies of each measurement
// assumes the bench drives true values; i_bad_ch swaps chosen copies for i_bad_val
`timescale 1ns/1ps
`default_nettype none
module adl_sensor_model
  import adl_pkg::*;
#(
  parameter int unsigned LW = 16
)(
  // true process values and fault injection
  input wire logic [LW-1:0] i_level,
  input wire logic [LW-1:0] i_pressure,
  input wire logic [NCH-1:0] i_bad_ch,
  input wire logic [LW-1:0] i_bad_val,
  // digitized copies, one per converter path
  output logic [NCH*LW-1:0] o_level,
  output logic [NCH*LW-1:0] o_pressure,
  // plant computer view of the copies
  output logic o_disagree
);
  // copies that differ from each other raise the disagreement alarm
  assign o_disagree = (i_bad_ch != '0) && (i_bad_ch != '1)
                      && (i_bad_val != i_level || i_bad_val != i_pressure);

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      o_level[c*LW+:LW] = i_bad_ch[c] ? i_bad_val : i_level;
      o_pressure[c*LW+:LW] = i_bad_ch[c] ? i_bad_val : i_pressure;
    end
  end
endmodule : adl_sensor_model
`default_nettype wire

//--- verif/adl_division_tb_top.sv
// self-checking bench for one division of depressurization actuation logic
// assumes shortened sustain and group delays given at the instance below
`timescale 1ns/1ps
`default_nettype none
module adl_division_tb_top;
  import adl_pkg::*;
  localparam logic [15:0] LSP = 16'h0100;
  localparam logic [15:0] PSP = 16'h0200;
  logic i_clock = 1'b0;
  logic i_srst = 1'b1;
  logic [15:0] lvl = 16'h0200, prs = 16'h0100;
  logic [NCH-1:0] bad = '0;
  logic [15:0] lsp = LSP, psp = PSP, bval = 16'h0000;
  logic [NCH*16-1:0] lvl_c, prs_c;
  logic [NDIV-1:0] plv = '0, ppr = '0, byp = '0, sarm = '0, sfire = '0;
  logic inh_t = 1'b0, inh_m = 1'b0;
  logic [NVALVE-1:0] varm = '0, vfire = '0, tsw = '1, cont = '1;
  logic lv, pv, refused, balarm, aalarm, slow, shigh, cool, grav, dis;
  logic [NDIV-1:0] bact;
  logic [NGRP-1:0] grp;
  logic [NRELIEF*RELIEF_DRV-1:0] rdrv;
  logic [NSQUIB*SQUIB_DRV-1:0] sdrv;
  logic [NVALVE-1:0] ener;
  logic [7:0] mon;
  int mismatches = 0, checked = 0, cyc = 0, n;
  assign mon = {grp, shigh, slow};
  always #5 i_clock = ~i_clock;

  adl_sensor_model #(.LW(16)) model_u (.i_level(lvl), .i_pressure(prs), .i_bad_ch(bad),
    .i_bad_val(bval), .o_level(lvl_c), .o_pressure(prs_c), .o_disagree(dis));
  adl_division #(.DIV(0), .LW(16), .LVL_CYC(20), .PRS_CYC(30),
    .GRP_CYC({NTMR{32'h0000000a}})) dut_u (
    .i_clock(i_clock), .i_srst(i_srst), .i_level(lvl_c), .i_pressure(prs_c),
    .i_level_sp(lsp), .i_pressure_sp(psp), .i_peer_lvl_vote(plv), .i_peer_prs_vote(ppr),
    .i_bypass_req(byp), .i_inhibit_transient(inh_t), .i_inhibit_manual(inh_m),
    .i_valve_arm(varm), .i_valve_fire(vfire), .i_sys_arm(sarm), .i_sys_fire(sfire),
    .i_test_sw_closed(tsw), .i_continuity_ok(cont), .o_lvl_vote(lv), .o_prs_vote(pv),
    .o_bypass_active(bact), .o_bypass_refused(refused), .o_bypass_alarm(balarm),
    .o_arm_alarm(aalarm), .o_sealed_low_level(slow), .o_sealed_high_press(shigh),
    .o_cooling_start(cool), .o_gravity_cooling_start(grav), .o_group_open(grp),
    .o_relief_drv(rdrv), .o_squib_drv(sdrv), .o_valve_energized(ener));

  task automatic wrap_up();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  // ceiling well above the few hundred cycles the tests need
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // inputs change 1 ns after the edge, outputs are read there too
  task automatic tick(input int k);
    repeat (k) @(posedge i_clock);
    #1;
  endtask : tick

  task automatic wait_bit(input int b, input int lim, output int cnt);
    cnt = 0;
    while (mon[b] !== 1'b1 && cnt < lim) begin
      tick(1);
      cnt++;
    end
  endtask : wait_bit

  task automatic rst();
    i_srst = 1'b1;
    {lvl, prs, bad} = {16'h0200, 16'h0100, 3'h0};
    {lsp, psp, bval} = {LSP, PSP, 16'h0000};
    {plv, ppr, byp, sarm, sfire, inh_t, inh_m} = '0;
    {varm, vfire, tsw, cont} = {36'h0, {36{1'b1}}};
    tick(6);
    i_srst = 1'b0;
    tick(2);
  endtask : rst

  task automatic t_votes();
    lvl = LSP - 16'h0001; tick(6); chk("lvl_vote", 1, lv);
    lvl = LSP; tick(6); chk("lvl_vote", 0, lv);
    prs = PSP + 16'h0001; tick(6); chk("prs_vote", 1, pv);
    prs = PSP; tick(6); chk("prs_vote", 0, pv);
    lsp = 16'h0300; psp = 16'h0050; tick(6); chk("lvl_vote", 1, lv);
    chk("prs_vote", 1, pv);
    lsp = LSP; psp = PSP; tick(6);
    bad = 3'b001; tick(6); chk("lvl_vote", 0, lv);
    chk("disagree", 1, dis);
    bad = 3'b011; tick(6); chk("lvl_vote", 1, lv);
    bad = 3'b110; bval = 16'hffff; tick(6); chk("prs_vote", 1, pv);
    chk("lvl_vote", 0, lv);
    bad = 3'b000; bval = 16'h0000; tick(6);
    chk("disagree", 0, dis);
    $display("test votes done");
  endtask : t_votes

  task automatic t_bypass();
    byp = 4'h2; tick(6); chk("bypass_active", 2, bact);
    chk("bypass_alarm", 1, balarm);
    byp = 4'h6; tick(6); chk("bypass_refused", 1, refused);
    chk("bypass_active", 2, bact);
    byp = 4'h0; tick(6); chk("bypass_active", 0, bact);
    chk("bypass_alarm", 0, balarm);
    $display("test bypass done");
  endtask : t_bypass

  task automatic t_seal();
    rst();
    cont[0] = 1'b0; tsw[1] = 1'b0; byp = 4'h2; plv = 4'h6; tick(40);
    chk("sealed_low", 0, slow);
    plv = 4'he; wait_bit(0, 40, n);
    chk("sealed_low", 1, slow);
    chk("seal_not_early", 1, n >= 20);
    chk("cooling_start", 1, cool);
    wait_bit(2, 6, n); chk("group0", 1, grp[0]);
    for (int k = 1; k < NGRP; k++) begin
      wait_bit(2 + k, 20, n); chk("group_gap", 1, n >= 8 && n <= 12);
    end
    plv = 4'h0; tick(4);
    chk("sealed_low_kept", 1, slow);
    chk("relief_drv", 32'h000fffff, rdrv);
    chk("squib_drv", 32'h00ffffff, sdrv);
    chk("energized", 32'h0003fffc, ener);
    $display("test seal done");
  endtask : t_seal

  task automatic t_press();
    rst();
    ppr = 4'h2; prs = PSP + 16'h0001; tick(20);
    prs = PSP; tick(5);
    prs = PSP + 16'h0001; tick(20);
    prs = PSP; tick(10);
    chk("sealed_high", 0, shigh);
    prs = PSP + 16'h0001; wait_bit(1, 60, n);
    chk("sealed_high", 1, shigh);
    chk("seal_not_early", 1, n >= 30);
    chk("gravity_start", 1, grav);
    $display("test pressure done");
  endtask : t_press

  task automatic t_manual();
    rst();
    inh_t = 1'b1; lvl = LSP - 16'h0001; plv = 4'h2; wait_bit(0, 60, n); tick(30);
    chk("group_open", 0, grp);
    inh_m = 1'b1; tick(1);
    inh_t = 1'b0; tick(30);
    chk("group_open", 0, grp);
    varm[3] = 1'b1; tick(6); chk("arm_alarm", 1, aalarm);
    chk("energized3", 0, ener[3]);
    vfire[3] = 1'b1; tick(8); chk("energized3", 1, ener[3]);
    vfire[4] = 1'b1; tick(8); chk("energized4", 0, ener[4]);
    sarm = 4'h3; tick(6);
    sfire = 4'h1; tick(10); chk("group0", 0, grp[0]);
    sfire = 4'h3; wait_bit(2, 20, n); chk("group0", 1, grp[0]);
    $display("test manual done");
  endtask : t_manual

  initial begin
    rst();
    t_votes();
    t_bypass();
    t_seal();
    t_press();
    t_manual();
    wrap_up();
  end
endmodule : adl_division_tb_top
`default_nettype wire
